// file: cpt_defines.vh
`ifndef CPT_DEFINES_VH
`define CPT_DEFINES_VH
// ----------------------------------------------------------------
// Register word addresses (byte address = 4 x index)
// ----------------------------------------------------------------
`define CPT_IDX_LOWER_CTRL   4'h0
`define CPT_IDX_UPPER_CTRL   4'h1
`define CPT_IDX_DUTY_LOW     4'h2
`define CPT_IDX_DUTY_HIGH    4'h3
`define CPT_IDX_PERIOD_LOW   4'h4
`define CPT_IDX_PERIOD_HIGH  4'h5
`define CPT_IDX_STATUS       4'h6
// ----------------------------------------------------------------
// Upper control fields
// ----------------------------------------------------------------
`define CPT_UC_MODE_LSB      0
`define CPT_UC_MODE_MSB      2
`define CPT_UC_RUN_BIT       3
`define CPT_UC_FFINIT_BIT    7
// ----------------------------------------------------------------
// Lower control fields
// ----------------------------------------------------------------
`define CPT_LC_SRC_LSB       4
`define CPT_LC_SRC_MSB       6
`define CPT_LC_DIVSEL_BIT    0
`define CPT_LC_SLOWMODE_BIT  1
// ----------------------------------------------------------------
// Modes of upper control
// ----------------------------------------------------------------
`define CPT_MODE_WARMUP      3'h5
`define CPT_MODE_PWM         3'h6
`define CPT_MODE_PPG         3'h7
// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define CPT_SRC_DIV11        3'h0
`define CPT_SRC_DIV7         3'h1
`define CPT_SRC_DIV5         3'h2
`define CPT_SRC_DIV3         3'h3
`define CPT_SRC_SLOW         3'h4
`define CPT_SRC_DIV2         3'h5
`define CPT_SRC_BASE         3'h6
`define CPT_SRC_EXT          3'h7
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CPT_RST_BYTE         8'h00
`define CPT_RST_WORD         16'h0000
`define CPT_SLOW_DIV_BITS    3
`define CPT_WAIT_CYCLES      1
`endif

// file: cpt_far_end.sv
`default_nettype none
module cpt_far_end (
  input  wire logic clk_sys_in,
  output var  logic event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial event_out = 1'b1;
  // ----------------------------------------------------------------
  // Event source: hold sets prompt or slow edges, never below one
  // ----------------------------------------------------------------
  task automatic send_edges(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk_sys_in);
      event_out <= 1'b0;
      repeat (hold) @(posedge clk_sys_in);
      event_out <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// file: cpt_tap_gen.v
`default_nettype none
// Free-running prescaler: one-cycle pulse per tap period
module cpt_tap_gen #(
  parameter WIDTH = 11
) (
  input  wire             clk_sys_in,
  input  wire             rst_in,
  output reg  [WIDTH-1:0] tick_out
);
  reg  [WIDTH-1:0] div_q;
  wire [WIDTH-1:0] div_d;
  wire [WIDTH-1:0] ones_w;
  assign div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};

  // Tap g fires when the low g+1 divider bits are all ones
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_tap
      assign ones_w[g] = &div_q[g:0];
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_q    <= {WIDTH{1'b0}};
      tick_out <= {WIDTH{1'b0}};
    end else begin
      div_q    <= div_d;
      tick_out <= ones_w;
    end
  end
endmodule
`default_nettype wire

// file: cpt_timer.v
`include "cpt_defines.vh"
`default_nettype none
module cpt_timer #(
  parameter CNT_W = 16,
  parameter DIV_W = 11
) (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        slow_tick_in,
  input  wire        event_input_pin_in,
  output reg         modulation_out_pin_out,
  output reg         pulse_gen_out_pin_out,
  output reg         period_interrupt_out
);
  // ----------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------
  wire [DIV_W-1:0] tick_w;
  cpt_tap_gen #(.WIDTH(DIV_W)) u_taps (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tick_out   (tick_w)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0]       lower_ctrl_q;
  reg [7:0]       upper_ctrl_q;
  reg [7:0]       duty_low_q;
  reg [7:0]       duty_high_q;
  reg [CNT_W-1:0] duty_act_q;
  reg [7:0]       period_low_q;
  reg [7:0]       period_high_q;
  reg [CNT_W-1:0] count_q;
  reg             ff_q;
  reg             buf_pend_q;
  reg             match_flag_q;
  reg [2:0]       slow_div_q;
  reg             slow_pulse_q;
  reg             ev_s1_q;
  reg             ev_s2_q;
  reg             ev_s3_q;
  reg             acc_q;

  wire [2:0] mode_w   = upper_ctrl_q[`CPT_UC_MODE_MSB:`CPT_UC_MODE_LSB];
  wire       run_w    = upper_ctrl_q[`CPT_UC_RUN_BIT];
  wire [2:0] src_w    = lower_ctrl_q[`CPT_LC_SRC_MSB:`CPT_LC_SRC_LSB];
  wire       divsel_w = lower_ctrl_q[`CPT_LC_DIVSEL_BIT];
  wire       slowm_w  = lower_ctrl_q[`CPT_LC_SLOWMODE_BIT];
  wire       is_pwm   = (mode_w == `CPT_MODE_PWM);
  wire       is_ppg   = (mode_w == `CPT_MODE_PPG);
  wire       is_wu    = (mode_w == `CPT_MODE_WARMUP);
  wire [CNT_W-1:0] period_w = {period_high_q, period_low_q};

  // ----------------------------------------------------------------
  // Slow clock /8 and external edge detect
  // ----------------------------------------------------------------
  // Event pin resynchronised; the second and third stages feed the edge detect
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      slow_div_q   <= 3'h0;
      slow_pulse_q <= 1'b0;
      ev_s1_q      <= 1'b1;
      ev_s2_q      <= 1'b1;
      ev_s3_q      <= 1'b1;
    end else begin
      slow_pulse_q <= slow_tick_in && (slow_div_q == 3'h7);
      if (slow_tick_in) begin
        slow_div_q <= slow_div_q + 3'h1;
      end
      ev_s1_q <= event_input_pin_in;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end
  // Falling edge counts; source must hold levels one cycle each
  wire ev_fall_w = ev_s3_q & ~ev_s2_q;

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  // Slow mode leaves the slow options and the event input; fast taps and base read as dead
  reg cnt_en;
  always @* begin
    cnt_en = 1'b0;
    case (src_w)
      `CPT_SRC_DIV11: cnt_en = (divsel_w | slowm_w) ? slow_pulse_q : tick_w[10];
      `CPT_SRC_DIV7:  cnt_en = slowm_w ? 1'b0 : tick_w[6];
      `CPT_SRC_DIV5:  cnt_en = slowm_w ? 1'b0 : tick_w[4];
      `CPT_SRC_DIV3:  cnt_en = slowm_w ? 1'b0 : tick_w[2];
      `CPT_SRC_SLOW:  cnt_en = slow_tick_in;
      `CPT_SRC_DIV2:  cnt_en = slowm_w ? 1'b0 : tick_w[0];
      `CPT_SRC_BASE:  cnt_en = ~slowm_w;
      `CPT_SRC_EXT:   cnt_en = ev_fall_w;
      default:        cnt_en = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  wire step_w     = run_w && cnt_en && (is_pwm || is_ppg || is_wu);
  wire duty_hit_w = (is_pwm || is_ppg) && (count_q == duty_act_q);
  wire ovf_w      = is_pwm && (count_q == {CNT_W{1'b1}});
  wire ppg_end_w  = is_ppg && (count_q == period_w);
  wire wu_end_w   = is_wu && (count_q[CNT_W-1:8] == period_high_q);
  wire wrap_w     = step_w && (ovf_w || ppg_end_w || wu_end_w);

  // Accesses act only in the answer cycle
  wire bus_wr = avs_write_in && !avs_waitrequest_out;
  wire bus_rd = avs_read_in && !avs_waitrequest_out;
  wire uc_wr  = bus_wr && (avs_address_in == `CPT_IDX_UPPER_CTRL);
  wire dh_wr  = bus_wr && (avs_address_in == `CPT_IDX_DUTY_HIGH);
  wire dl_wr  = bus_wr && (avs_address_in == `CPT_IDX_DUTY_LOW);
  wire st_clr = bus_wr && (avs_address_in == `CPT_IDX_STATUS) && avs_writedata_in[0];
  wire start_w   = uc_wr && avs_writedata_in[`CPT_UC_RUN_BIT] && !run_w;
  wire ff_load_w = uc_wr && !avs_writedata_in[`CPT_UC_RUN_BIT] && !run_w;
  // Duty and end match in one step cancel and leave the level
  wire toggle_w  = step_w && !is_wu && (duty_hit_w ^ (ovf_w | ppg_end_w));

  reg [CNT_W-1:0] count_d;
  reg             ff_d;
  reg             match_flag_d;
  // Start zeroes the count so the first period is full length
  always @* begin
    count_d = count_q;
    if (start_w) begin
      count_d = `CPT_RST_WORD;
    end else if (wrap_w) begin
      count_d = `CPT_RST_WORD;
    end else if (step_w) begin
      count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Init level loads only while stopped; stopping write leaves pin alone
  always @* begin
    ff_d = ff_q;
    if (ff_load_w) begin
      ff_d = avs_writedata_in[`CPT_UC_FFINIT_BIT];
    end else if (toggle_w) begin
      ff_d = ~ff_q;
    end
  end

  // Sticky match status, set beats clear
  always @* begin
    match_flag_d = match_flag_q;
    if (wrap_w) begin
      match_flag_d = 1'b1;
    end else if (st_clr) begin
      match_flag_d = 1'b0;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_q              <= `CPT_RST_WORD;
      ff_q                 <= 1'b0;
      period_interrupt_out <= 1'b0;
      match_flag_q         <= 1'b0;
    end else begin
      period_interrupt_out <= wrap_w;
      count_q              <= count_d;
      ff_q                 <= ff_d;
      match_flag_q         <= match_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and duty buffer
  // ----------------------------------------------------------------
  // Outside PWM running each byte write loads at once; PWM running waits for the upper byte, then period end
  wire            pwm_run_w = is_pwm && run_w;
  reg [CNT_W-1:0] duty_act_d;
  reg             buf_pend_d;
  // A high write colliding with the wrap buffers a mixed pair once
  always @* begin
    buf_pend_d = buf_pend_q;
    duty_act_d = duty_act_q;
    if (dh_wr && pwm_run_w) begin
      buf_pend_d = 1'b1;
    end else if (wrap_w) begin
      buf_pend_d = 1'b0;
    end
    if (dh_wr && !pwm_run_w) begin
      duty_act_d = {avs_writedata_in[7:0], duty_low_q};
    end else if (wrap_w && is_pwm && (buf_pend_q || dh_wr)) begin
      duty_act_d = {duty_high_q, duty_low_q};
    end else if (dl_wr && !pwm_run_w) begin
      duty_act_d = {duty_act_q[CNT_W-1:8], avs_writedata_in[7:0]};
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lower_ctrl_q  <= `CPT_RST_BYTE;
      upper_ctrl_q  <= `CPT_RST_BYTE;
      duty_low_q    <= `CPT_RST_BYTE;
      duty_high_q   <= `CPT_RST_BYTE;
      period_low_q  <= `CPT_RST_BYTE;
      period_high_q <= `CPT_RST_BYTE;
      duty_act_q    <= `CPT_RST_WORD;
      buf_pend_q    <= 1'b0;
    end else begin
      if (bus_wr) begin
        case (avs_address_in)
          `CPT_IDX_LOWER_CTRL:  lower_ctrl_q  <= avs_writedata_in[7:0];
          `CPT_IDX_UPPER_CTRL:  upper_ctrl_q  <= avs_writedata_in[7:0];
          `CPT_IDX_DUTY_LOW:    duty_low_q    <= avs_writedata_in[7:0];
          `CPT_IDX_DUTY_HIGH:   duty_high_q   <= avs_writedata_in[7:0];
          `CPT_IDX_PERIOD_LOW:  period_low_q  <= avs_writedata_in[7:0];
          `CPT_IDX_PERIOD_HIGH: period_high_q <= avs_writedata_in[7:0];
          default: ;
        endcase
      end
      buf_pend_q <= buf_pend_d;
      duty_act_q <= duty_act_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle per access
  // ----------------------------------------------------------------
  // A fresh request is one not already being answered
  wire req_w = (avs_read_in || avs_write_in) && avs_waitrequest_out && !acc_q;
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (avs_address_in)
      `CPT_IDX_LOWER_CTRL:  rd_d[7:0] = lower_ctrl_q;
      `CPT_IDX_UPPER_CTRL:  rd_d[7:0] = upper_ctrl_q;
      `CPT_IDX_DUTY_LOW:    rd_d[7:0] = is_pwm ? duty_act_q[7:0] : duty_low_q;
      `CPT_IDX_DUTY_HIGH:   rd_d[7:0] = is_pwm ? duty_act_q[15:8] : duty_high_q;
      `CPT_IDX_PERIOD_LOW:  rd_d[7:0] = period_low_q;
      `CPT_IDX_PERIOD_HIGH: rd_d[7:0] = period_high_q;
      `CPT_IDX_STATUS:      rd_d[2:0] = {ff_q, run_w, match_flag_q};
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      acc_q               <= 1'b0;
    end else begin
      acc_q               <= req_w;
      avs_waitrequest_out <= !req_w;
      if (req_w) begin
        avs_readdata_out <= rd_d;
      end
      if (bus_rd) begin
        avs_readdata_out <= avs_readdata_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // One register stage behind the flip-flop keeps outputs registered
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      modulation_out_pin_out <= 1'b1;
      pulse_gen_out_pin_out  <= 1'b1;
    end else begin
      modulation_out_pin_out <= ~ff_q;
      pulse_gen_out_pin_out  <= ~ff_q;
    end
  end
endmodule
`default_nettype wire

// file: cpt_timer_checker.sv
`default_nettype none
module cpt_timer_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        modulation_out_pin_out,
  input wire logic        pulse_gen_out_pin_out,
  input wire logic        period_interrupt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  property p_reset;
    disable iff (1'b0) rst_in |=> avs_waitrequest_out && modulation_out_pin_out
      && pulse_gen_out_pin_out && !period_interrupt_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state after reset wrong");
  property p_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");
  property p_one_low;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_one_low: assert property (p_one_low)
    else $error("waitrequest low too long");
  property p_low_cause;
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_low_cause: assert property (p_low_cause)
    else $error("answer without request");
  property p_rdata_hold;
    !avs_read_in && !avs_write_in && avs_waitrequest_out |=> $stable(avs_readdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved while idle");
  property p_pins_same;
    modulation_out_pin_out == pulse_gen_out_pin_out;
  endproperty
  a_pins_same: assert property (p_pins_same)
    else $error("output pins differ");
  property p_irq_pulse;
    period_interrupt_out |=> !period_interrupt_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  // Stopped counter cannot wrap or toggle this soon
  property p_quiet;
    $fell(rst_in) |-> (!period_interrupt_out && modulation_out_pin_out) [*3];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity right after reset");
endmodule
bind cpt_timer cpt_timer_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .modulation_out_pin_out(modulation_out_pin_out),
  .pulse_gen_out_pin_out(pulse_gen_out_pin_out), .period_interrupt_out(period_interrupt_out));
`default_nettype wire

// file: tb.sv
`include "cpt_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [3:0]  adr        = 4'h0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdata      = 32'h0000_0000;
  logic        slow_tick  = 1'b0;
  logic [31:0] got;
  wire  [31:0] rdata;
  wire         wait_req, mod_pin, ppg_pin, irq, ev_pin;
  int          fails = 0, n_compared = 0, cyc = 0, nirq = 0, k, t0, c0, n0, ia, ib;
  cpt_timer u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .slow_tick_in(slow_tick),
    .event_input_pin_in(ev_pin), .modulation_out_pin_out(mod_pin),
    .pulse_gen_out_pin_out(ppg_pin), .period_interrupt_out(irq));
  cpt_far_end u_far (.clk_sys_in(clk_sys_in), .event_out(ev_pin));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------------------------------
  // Cycle count, slow tick, interrupt tally, hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    slow_tick <= (cyc % 8 == 7);
    if (irq === 1'b1) nirq <= nirq + 1;
    if (cyc == 90000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input [3:0] a, input [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic set16(input [3:0] a, input [15:0] v);
    bus(1'b1, a, v[7:0]);
    bus(1'b1, a + 4'h1, v[15:8]);
  endtask
  task automatic wait_pin(input logic v, output int t);
    t = 0;
    while (mod_pin !== v && t < 70000) begin
      @(posedge clk_sys_in);
      t++;
    end
  endtask
  task automatic wait_irq(output int c);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
    end
    c = cyc;
  endtask
  function automatic [7:0] uc(input logic ff, input logic run, input [2:0] m);
    uc = {ff, 3'b000, run, m};
  endfunction
  function automatic int dv(input int s);
    case (s)
      0: dv = 2048;
      1: dv = 128;
      2: dv = 32;
      3, 4: dv = 8;
      5: dv = 2;
      default: dv = 1;
    endcase
  endfunction
  // Stop, then a second write reloads the flip-flop at 0
  task automatic halt(input [2:0] m);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b0, m));
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b0, m));
    repeat (4) @(posedge clk_sys_in);
    chk(mod_pin, 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk({mod_pin, ppg_pin, irq}, 3'b110);
    bus(1'b0, `CPT_IDX_STATUS, 8'h00);
    chk(got, 32'h0000_0000);
    bus(1'b1, 4'hF, 8'hFF);
    bus(1'b0, 4'hF, 8'h00);
    chk(got, 32'h0000_0000);
    bus(1'b1, `CPT_IDX_LOWER_CTRL, {1'b0, `CPT_SRC_BASE, 4'h0});
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b1, 1'b0, `CPT_MODE_PPG));
    repeat (4) @(posedge clk_sys_in);
    chk({mod_pin, ppg_pin}, 2'b00);
    halt(`CPT_MODE_PPG);
    $display("test reset and init done");
    set16(`CPT_IDX_PERIOD_LOW, 16'hFFFF);
    set16(`CPT_IDX_DUTY_LOW, 16'h0002);
    for (k = 0; k < 7; k++) begin
      bus(1'b1, `CPT_IDX_LOWER_CTRL, {1'b0, k[2:0], 4'h0});
      bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_PPG));
      wait_pin(1'b0, t0);
      chk(t0 >= 2 * dv(k) && t0 <= 3 * dv(k) + 8, 1);
      halt(`CPT_MODE_PPG);
    end
    bus(1'b1, `CPT_IDX_LOWER_CTRL, {1'b0, `CPT_SRC_DIV11, 4'h1});
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_PPG));
    wait_pin(1'b0, t0);
    chk(t0 >= 128 && t0 <= 200, 1);
    halt(`CPT_MODE_PPG);
    $display("test sources done");
    set16(`CPT_IDX_DUTY_LOW, 16'h0004);
    bus(1'b1, `CPT_IDX_LOWER_CTRL, {1'b0, `CPT_SRC_EXT, 4'h0});
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_PPG));
    u_far.send_edges(4, 2);
    repeat (8) @(posedge clk_sys_in);
    chk(mod_pin, 1'b1);
    u_far.send_edges(1, 4);
    repeat (8) @(posedge clk_sys_in);
    chk(mod_pin, 1'b0);
    halt(`CPT_MODE_PPG);
    $display("test event input done");
    bus(1'b1, `CPT_IDX_LOWER_CTRL, {1'b0, `CPT_SRC_BASE, 4'h0});
    set16(`CPT_IDX_PERIOD_LOW, 16'h0030);
    set16(`CPT_IDX_DUTY_LOW, 16'h0010);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_PPG));
    wait_pin(1'b0, t0);
    n0 = nirq;
    wait_pin(1'b1, t0);
    chk(t0, 32'h0000_0020);
    set16(`CPT_IDX_DUTY_LOW, 16'h0018);
    chk(nirq - n0, 1);
    wait_pin(1'b0, t0);
    wait_pin(1'b1, t0);
    chk(t0, 32'h0000_0018);
    bus(1'b0, `CPT_IDX_STATUS, 8'h00);
    chk(got, 32'h0000_0003);
    bus(1'b1, `CPT_IDX_STATUS, 8'h01);
    bus(1'b0, `CPT_IDX_STATUS, 8'h00);
    chk(got, 32'h0000_0002);
    halt(`CPT_MODE_PPG);
    $display("test pulse generator done");
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b0, `CPT_MODE_PWM));
    set16(`CPT_IDX_DUTY_LOW, 16'hFF00);
    bus(1'b0, `CPT_IDX_DUTY_HIGH, 8'h00);
    chk(got, 32'h0000_00FF);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_PWM));
    wait_pin(1'b0, t0);
    c0 = cyc;
    set16(`CPT_IDX_DUTY_LOW, 16'h0040);
    bus(1'b0, `CPT_IDX_DUTY_HIGH, 8'h00);
    chk(got, 32'h0000_00FF);
    n0 = nirq;
    wait_pin(1'b1, t0);
    wait_pin(1'b0, t0);
    chk(cyc - c0, 32'h0000_0140);
    chk(nirq - n0, 1);
    bus(1'b0, `CPT_IDX_DUTY_LOW, 8'h00);
    chk(got, 32'h0000_0040);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b0, `CPT_MODE_PWM));
    repeat (80) @(posedge clk_sys_in);
    chk(mod_pin, 1'b0);
    halt(`CPT_MODE_PWM);
    $display("test modulation done");
    set16(`CPT_IDX_PERIOD_LOW, 16'h0100);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_WARMUP));
    wait_irq(c0);
    wait_irq(ia);
    ia = ia - c0;
    halt(`CPT_MODE_WARMUP);
    set16(`CPT_IDX_PERIOD_LOW, 16'h01FF);
    bus(1'b1, `CPT_IDX_UPPER_CTRL, uc(1'b0, 1'b1, `CPT_MODE_WARMUP));
    wait_irq(c0);
    wait_irq(ib);
    chk(ib - c0, ia);
    chk(ia >= 256 && ia <= 257, 1);
    chk(mod_pin, 1'b1);
    halt(`CPT_MODE_WARMUP);
    $display("test warm-up done");
    wrap_up();
  end
endmodule
`default_nettype wire
